// ===== rtl/charge_cycle_ctrl.sv
/*
 * Charge cycle sequencer: phase selection, termination, recharge,
 * indicator pin, interrupt pulses and power-path decisions.
 * Assumes analog comparator levels arrive asynchronously and are
 * synchronised here; millivolt buses are quasi-static.
 */
`timescale 1ns/100ps
module charge_cycle_ctrl
(
    // clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_rst_n,
    // host control bits
    input  wire logic                            i_charge_enable_bit,
    input  wire logic                            i_indicator_pin_disable,
    input  wire logic [1:0]                      i_recharge_offset_select,
    input  wire logic                            i_linear_pass_disable,
    input  wire logic                            i_charge_event_mask,
    input  wire logic [1:0]                      i_cell_count_sel,
    input  wire logic [15:0]                     i_charge_current_ma,
    // pins and comparator levels
    input  wire logic                            i_charge_enable_pin_n,
    input  wire logic                            i_converter_up,
    input  wire logic                            i_thermistor_fault,
    input  wire logic                            i_timer_fault,
    input  wire logic                            i_current_below_term,
    input  wire logic                            i_cv_loop_active,
    input  wire logic                            i_thermal_reg,
    input  wire logic                            i_input_voltage_limit_loop,
    input  wire logic                            i_input_current_limit_loop,
    input  wire logic                            i_sys_below_min,
    input  wire logic                            i_sys_below_bat,
    input  wire logic                            i_bat_depleted,
    // battery voltage in millivolts
    input  wire logic [charge_cycle_pkg::MV_W-1:0] i_vbat_mv,
    // status and control outputs
    output logic [2:0]                           o_charge_phase_code,
    output logic                                 o_host_int_pulse,
    output logic                                 o_indicator_out,
    output logic                                 o_indicator_oe_n,
    output logic                                 o_input_voltage_limit_flag,
    output logic                                 o_input_current_limit_flag,
    output logic                                 o_battery_switch_on,
    output logic                                 o_hold_per_cell,
    output logic                                 o_min_sys_hold,
    output logic                                 o_converter_current_loop,
    output logic [15:0]                          o_current_limit_ma,
    output logic                                 o_timer_half_rate
);
    import charge_cycle_pkg::*;

    localparam int NSYNC = 12;
    localparam logic [NSYNC-1:0] SYNC_RST = 12'h800; // enable pin idles high

    // two-flop synchronisers for all asynchronous levels
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] sync1_ff;
    logic [NSYNC-1:0] sync2_ff;
    assign async_in = {i_charge_enable_pin_n, i_converter_up, i_thermistor_fault,
                       i_timer_fault, i_current_below_term, i_cv_loop_active,
                       i_thermal_reg, i_input_voltage_limit_loop,
                       i_input_current_limit_loop, i_sys_below_min,
                       i_sys_below_bat, i_bat_depleted};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g++)
        begin : g_sync
            always_ff @(posedge i_clk)
            begin
                sync1_ff[g] <= i_rst_n ? async_in[g] : SYNC_RST[g];
                sync2_ff[g] <= i_rst_n ? sync1_ff[g] : SYNC_RST[g];
            end
        end
    endgenerate

    logic s_pin_n, s_conv, s_therm, s_tfault, s_iterm, s_cv, s_treg;
    logic s_vlim, s_ilim, s_sysmin, s_sysbat, s_depl;
    assign {s_pin_n, s_conv, s_therm, s_tfault, s_iterm, s_cv, s_treg,
            s_vlim, s_ilim, s_sysmin, s_sysbat, s_depl} = sync2_ff;

    // enable, start and termination qualifiers
    logic enabled;
    logic start_ok;
    logic regulating;
    logic [15:0] vtarget;
    logic [15:0] rechg_ofs;
    logic [19:0] lowv_prod;
    logic [15:0] lowv_mv;
    logic [15:0] rechg_mv;
    logic bat_below_rechg;
    logic term_ok;

    assign enabled    = i_charge_enable_bit && !s_pin_n;                 // RULE1
    assign start_ok   = s_conv && enabled && !s_therm && !s_tfault;       // RULE2
    assign regulating = s_vlim || s_ilim || s_treg;

    // target voltage per cell count
    always_comb
    begin
        case (i_cell_count_sel)                                           // RULE22
            2'h0: vtarget = VTARGET_1S_MV;
            2'h1: vtarget = VTARGET_2S_MV;
            2'h2: vtarget = VTARGET_3S_MV;
            default: vtarget = VTARGET_4S_MV;
        endcase
        case (i_recharge_offset_select)                                   // RULE4
            2'h0: rechg_ofs = RECHG_OFS0_MV;
            2'h1: rechg_ofs = RECHG_OFS1_MV;
            2'h2: rechg_ofs = RECHG_OFS2_MV;
            default: rechg_ofs = RECHG_OFS3_MV;
        endcase
    end

    assign lowv_prod       = 20'(vtarget) * 20'(LOWV_RATIO_NUM);          // RULE13
    assign lowv_mv         = lowv_prod[19:4];
    assign rechg_mv        = vtarget - rechg_ofs;
    assign bat_below_rechg = i_vbat_mv < rechg_mv;
    assign term_ok = s_iterm && !bat_below_rechg && s_cv && !regulating;  // RULE3 RULE14

    // hold counter for the 2.5 V per cell step
    logic [CNT_W-1:0] hold_cnt_ff;
    logic             hold_done;
    assign hold_done = (hold_cnt_ff == CNT_W'(SHORTZ_CYC - 1));

    // phase sequencer
    phase_e phase_ff;
    phase_e nxt_phase;
    logic   hold_ff;
    always_comb
    begin
        nxt_phase = phase_ff;
        if (!start_ok && phase_ff != PH_DONE)
            nxt_phase = PH_IDLE;
        else if (!enabled)
            nxt_phase = PH_IDLE;                                          // RULE5
        else
        begin
            case (phase_ff)
                PH_IDLE:
                begin
                    if (i_vbat_mv < DEEP_DISCHARGE_MV)                    // RULE10
                        nxt_phase = PH_TRICKLE;
                    else if (i_vbat_mv < lowv_mv)
                        nxt_phase = PH_PRECHG;
                    else
                        nxt_phase = PH_FAST;
                end
                PH_TRICKLE:
                begin
                    if (hold_ff && hold_done)                             // RULE12
                        nxt_phase = PH_PRECHG;
                end
                PH_PRECHG:
                begin
                    if (i_vbat_mv < DEEP_DISCHARGE_MV)
                        nxt_phase = PH_TRICKLE;
                    else if (i_vbat_mv >= lowv_mv)
                        nxt_phase = PH_FAST;
                end
                PH_FAST:
                begin
                    if (i_vbat_mv < lowv_mv)
                        nxt_phase = PH_PRECHG;
                    else if (s_cv)
                        nxt_phase = PH_TAPER;
                end
                PH_TAPER:
                begin
                    if (term_ok)                                          // RULE3
                        nxt_phase = PH_DONE;
                    else if (!s_cv)
                        nxt_phase = PH_FAST;
                end
                PH_DONE:
                begin
                    if (bat_below_rechg && start_ok)                      // RULE4
                        nxt_phase = PH_IDLE;
                end
                default: nxt_phase = PH_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            phase_ff <= PH_IDLE;
        else
            phase_ff <= nxt_phase;
    end

    // trickle exit hold: 2.5 V/cell regulation after 2.2 V crossing
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || phase_ff != PH_TRICKLE)
        begin
            hold_ff     <= 1'b0;
            hold_cnt_ff <= '0;
        end
        else if (!hold_ff && i_vbat_mv >= DEEP_DISCHARGE_MV)              // RULE11
            hold_ff <= 1'b1;
        else if (hold_ff && !hold_done)
            hold_cnt_ff <= hold_cnt_ff + 1'b1;
    end

    // phase code output and interrupt pulse on each change
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_charge_phase_code <= PH_IDLE;
            o_host_int_pulse    <= 1'b0;
        end
        else
        begin
            o_charge_phase_code <= phase_ff;                              // RULE8
            o_host_int_pulse    <= (phase_ff != o_charge_phase_code)      // RULE9
                                   && !i_charge_event_mask;               // RULE23
        end
    end

    // blink timer for the fault indication
    logic [CNT_W-1:0] blink_cnt_ff;
    logic             blink_ff;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            blink_cnt_ff <= '0;
            blink_ff     <= 1'b0;
        end
        else if (blink_cnt_ff == CNT_W'(BLINK_HALF_CYC - 1))             // RULE24
        begin
            blink_cnt_ff <= '0;
            blink_ff     <= !blink_ff;
        end
        else
            blink_cnt_ff <= blink_cnt_ff + 1'b1;
    end

    // indicator pin: low charging, high done or disabled, blink on fault
    logic charging;
    logic fault;
    assign charging = phase_ff != PH_IDLE && phase_ff != PH_DONE;
    assign fault    = enabled && (s_therm || s_tfault);
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_indicator_out  <= 1'b1;
            o_indicator_oe_n <= 1'b1;
        end
        else
        begin
            o_indicator_oe_n <= i_indicator_pin_disable;                  // RULE7
            if (fault)
                o_indicator_out <= blink_ff;                              // RULE6
            else
                o_indicator_out <= !charging;                             // RULE6
        end
    end

    // input limit flags and timer rate
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_input_voltage_limit_flag <= 1'b0;
            o_input_current_limit_flag <= 1'b0;
            o_timer_half_rate          <= 1'b0;
        end
        else
        begin
            o_input_voltage_limit_flag <= s_vlim;                         // RULE15
            o_input_current_limit_flag <= s_ilim;                         // RULE15
            o_timer_half_rate          <= charging && regulating;         // RULE14
        end
    end

    // supplement mode and battery switch
    logic supplement_ff;
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            supplement_ff <= 1'b0;
        else if (s_depl)
            supplement_ff <= 1'b0;                                        // RULE21
        else if (s_sysbat)
            supplement_ff <= 1'b1;                                        // RULE20
    end

    // power path: minimum system hold, current loop choice and cap
    logic ldo_off;
    logic [15:0] nxt_limit;
    assign ldo_off = i_linear_pass_disable && phase_ff != PH_TRICKLE;     // RULE19
    always_comb
    begin
        nxt_limit = i_charge_current_ma;
        if (!charging || (s_sysmin && !ldo_off && i_vbat_mv < vtarget &&  // RULE16
            supplement_ff))
            nxt_limit = 16'h0000;
        else if (s_sysmin && !ldo_off && i_charge_current_ma > LDO_CAP_MA)
            nxt_limit = LDO_CAP_MA;                                       // RULE17
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_battery_switch_on      <= 1'b0;
            o_hold_per_cell          <= 1'b0;
            o_min_sys_hold           <= 1'b1;
            o_converter_current_loop <= 1'b0;
            o_current_limit_ma       <= 16'h0000;
        end
        else
        begin
            o_battery_switch_on      <= supplement_ff || (charging && phase_ff != PH_DONE);
            o_hold_per_cell          <= hold_ff;                          // RULE12
            o_min_sys_hold           <= !ldo_off;                         // RULE18
            o_converter_current_loop <= ldo_off;                          // RULE18
            o_current_limit_ma       <= nxt_limit;
        end
    end

    // checks
    a_enable_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !enabled |=> phase_ff == PH_IDLE || phase_ff == PH_DONE) // RULE1
        else $error("charging while disabled");
    a_start_cond: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_ff == PH_IDLE && nxt_phase != PH_IDLE |-> start_ok) // RULE2
        else $error("cycle started without qualifiers");
    a_term_inhibit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_ff == PH_TAPER && regulating |=> phase_ff != PH_DONE) // RULE14
        else $error("termination during regulation");
    a_int_on_change: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $changed(phase_ff) && !i_charge_event_mask |=> o_host_int_pulse) // RULE9
        else $error("missing interrupt on phase change");
    a_int_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_charge_event_mask |=> !o_host_int_pulse) // RULE23
        else $error("interrupt while masked");
    a_code_follows: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_charge_phase_code == $past(phase_ff) && o_charge_phase_code != PH_RSVD) // RULE8
        else $error("phase code mismatch");
    a_indicator_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_indicator_pin_disable |=> o_indicator_oe_n) // RULE7
        else $error("indicator driven while disabled");
    a_ldo_cap: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_sysmin && !ldo_off |=> o_current_limit_ma <= LDO_CAP_MA) // RULE17
        else $error("current over linear cap");
    a_supp_exit: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        s_depl |=> !supplement_ff ##1 (!o_battery_switch_on || $past(charging))) // RULE21
        else $error("supplement kept after depletion");
    a_hold_len: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_ff == PH_TRICKLE && nxt_phase == PH_PRECHG |-> hold_done) // RULE12
        else $error("hold step too short");
    c_full_cycle: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_ff == PH_TAPER ##1 phase_ff == PH_DONE);
    c_trickle_exit: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_ff == PH_TRICKLE ##1 phase_ff == PH_PRECHG);
    c_recharge: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        phase_ff == PH_DONE ##1 phase_ff == PH_IDLE);
    c_supplement: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(supplement_ff));
endmodule

// ===== rtl/charge_cycle_pkg.sv
/*
 * Constants for the charge cycle controller: phase codes, recharge
 * offsets, charge voltage targets, current caps and timing counts.
 * Assumes a single 40 MHz device clock.
 */
// Functional notes
// [RULE1] charging enabled only when enable bit is 1 and enable pin low
// [RULE2] new cycle needs converter up, enabled, no thermistor, no timer fault
// [RULE3] terminate when current low, voltage above recharge, no regulation
// [RULE4] after termination, restart when battery falls below recharge level
// [RULE5] toggling enable pin or bit after termination starts fresh cycle
// [RULE6] indicator low while charging, high done or disabled, blinks on fault
// [RULE7] indicator disable bit releases the indicator pin
// [RULE8] three-bit phase code encodes not charging through termination done
// [RULE9] every phase code change issues a host interrupt pulse
// [RULE10] cycle start picks trickle, pre-charge or fast by battery voltage
// [RULE11] trickle to pre-charge switch at fixed 2.2 V threshold
// [RULE12] regulate 2.5 V per cell for fixed duration in that transition
// [RULE13] pre-charge exit threshold is a ratio of charge voltage target
// [RULE14] power-limit or thermal regulation inhibits termination, halves timer
// [RULE15] input voltage and current limit flags follow their loops
// [RULE16] system below minimum reduces charge current to hold rail
// [RULE17] minimum-system regulation in linear mode caps current at 2 A
// [RULE18] linear-pass disable uses converter loop, drops rail minimum hold
// [RULE19] in trickle, linear-pass disable changes nothing
// [RULE20] system below battery enters supplement mode, battery switch on
// [RULE21] supplement mode ends when battery drops below depletion level
// [RULE22] default targets 4.2, 8.4, 12.6, 16.8 V for one to four cells
// [RULE23] charge event mask suppresses every charge cycle interrupt pulse
// [RULE24] fault blink period about one second from device clock
package charge_cycle_pkg;
    localparam int unsigned CLK_HZ            = 40_000_000;
    localparam int unsigned BLINK_PERIOD_MS   = 1000;
    localparam int unsigned BLINK_HALF_CYC    = CLK_HZ / 1000 * BLINK_PERIOD_MS / 2;
    localparam int unsigned SHORTZ_TIME_US    = 1000;
    localparam int unsigned SHORTZ_CYC        = CLK_HZ / 1_000_000 * SHORTZ_TIME_US;
    localparam int unsigned CNT_W             = 25;

    // millivolt quantities on the comparator buses
    localparam int unsigned MV_W              = 16;
    localparam logic [15:0] DEEP_DISCHARGE_MV = 16'h0898; // 2200 mV
    localparam logic [15:0] HOLD_PER_CELL_MV  = 16'h09c4; // 2500 mV
    localparam logic [15:0] RECHG_OFS0_MV     = 16'h0064; // 100 mV
    localparam logic [15:0] RECHG_OFS1_MV     = 16'h00c8; // 200 mV default
    localparam logic [15:0] RECHG_OFS2_MV     = 16'h012c; // 300 mV
    localparam logic [15:0] RECHG_OFS3_MV     = 16'h0190; // 400 mV
    localparam logic [1:0]  RECHG_SEL_RESET   = 2'h1;
    localparam logic [15:0] VTARGET_1S_MV     = 16'h1068; // 4200 mV
    localparam logic [15:0] VTARGET_2S_MV     = 16'h20d0; // 8400 mV
    localparam logic [15:0] VTARGET_3S_MV     = 16'h3138; // 12600 mV
    localparam logic [15:0] VTARGET_4S_MV     = 16'h41a0; // 16800 mV
    // pre-charge exit as target * num / 16
    localparam logic [3:0]  LOWV_RATIO_NUM    = 4'hb;
    localparam logic [15:0] LDO_CAP_MA        = 16'h07d0; // 2000 mA

    typedef enum logic [2:0] {
        PH_IDLE    = 3'b000,
        PH_TRICKLE = 3'b001,
        PH_PRECHG  = 3'b010,
        PH_FAST    = 3'b011,
        PH_TAPER   = 3'b100,
        PH_RSVD    = 3'b101,
        PH_TOPOFF  = 3'b110,
        PH_DONE    = 3'b111
    } phase_e;
endpackage

// ===== tb/charge_env_model.sv
/*
 * Battery and adapter stand-in: presents battery millivolts and the
 * constant-voltage and termination-current comparator levels.
 * Assumes the bench chooses the battery voltage and cell count.
 */
`timescale 1ns/100ps
module charge_env_model
(
    // clock
    input  wire logic        i_clk,
    // bench setting
    input  wire logic [15:0] i_vbat_set,
    input  wire logic [1:0]  i_cells,
    // comparator levels to the block
    output logic [15:0]      o_vbat_mv,
    output logic             o_cv_loop,
    output logic             o_below_term
);
    // cv loop engages at the cell target, current decays a cycle later
    always_ff @(posedge i_clk)
    begin
        o_vbat_mv    <= i_vbat_set;
        o_cv_loop    <= 32'(i_vbat_set) >= 32'd4200 * (32'(i_cells) + 32'd1);
        o_below_term <= o_cv_loop;
    end
endmodule

// ===== tb/tb_charge_cycle_ctrl.sv
/*
 * Self-checking bench for the charge cycle sequencer.
 * Assumes 1-cell default, rising-edge stimulus and a 40 MHz clock.
 */
`timescale 1ns/100ps
module tb_charge_cycle_ctrl;
    logic        i_clk = 0, i_rst_n = 0, en_bit = 0, ind_dis = 0, lpd = 0, mask = 0;
    logic [1:0]  rsel = 2'h1, cells = 2'h0;
    logic [15:0] cur = 16'h0bb8, vset = 16'h0dac, vbat, lim;
    logic        en_pin_n = 1, conv = 1, therm = 0, tflt = 0, thr = 0, vl = 0, il = 0;
    logic        smin = 0, sbat = 0, depl = 0, cv, bterm;
    logic [2:0]  code;
    logic        intp, ind, ind_oe_n, vf, cf, sw, hold, msh, ccl, half;
    logic [2:0]  exp_q[$];
    int          err_total = 0, samples_checked = 0, seed = 32'h66b3eb98;

    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;

    charge_env_model u_env (.i_clk(i_clk), .i_vbat_set(vset), .i_cells(cells),
        .o_vbat_mv(vbat), .o_cv_loop(cv), .o_below_term(bterm));

    charge_cycle_ctrl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_charge_enable_bit(en_bit),
        .i_indicator_pin_disable(ind_dis), .i_recharge_offset_select(rsel),
        .i_linear_pass_disable(lpd), .i_charge_event_mask(mask), .i_cell_count_sel(cells),
        .i_charge_current_ma(cur), .i_charge_enable_pin_n(en_pin_n), .i_converter_up(conv),
        .i_thermistor_fault(therm), .i_timer_fault(tflt), .i_current_below_term(bterm),
        .i_cv_loop_active(cv), .i_thermal_reg(thr), .i_input_voltage_limit_loop(vl),
        .i_input_current_limit_loop(il), .i_sys_below_min(smin), .i_sys_below_bat(sbat),
        .i_bat_depleted(depl), .i_vbat_mv(vbat), .o_charge_phase_code(code),
        .o_host_int_pulse(intp), .o_indicator_out(ind), .o_indicator_oe_n(ind_oe_n),
        .o_input_voltage_limit_flag(vf), .o_input_current_limit_flag(cf),
        .o_battery_switch_on(sw), .o_hold_per_cell(hold), .o_min_sys_hold(msh),
        .o_converter_current_loop(ccl), .o_current_limit_ma(lim), .o_timer_half_rate(half));

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask

    task automatic complete_run();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // bounded wait until every noted phase change has been seen
    task automatic drain(input int lim_c);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < lim_c)
        begin
            @(posedge i_clk);
            k++;
        end
        if (exp_q.size() != 0)
        begin
            chk("pulse_timeout", 16'h0, 16'h1);
            complete_run();
        end
        cyc(2);
    endtask

    // each interrupt pulse takes the oldest noted phase code
    always @(posedge i_clk)
        if (intp === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("stray_pulse", 16'h0, 16'h1);
            else
                chk("phase_code", 16'(exp_q.pop_front()), 16'(code));
        end

    initial
    begin
        cyc(3);
        i_rst_n <= 1;
        cyc(2);
        chk("reset_code", 16'h0, 16'(code));
        chk("ind_disabled", 16'h1, 16'(ind));
        // start above pre-charge exit, run through taper to done
        exp_q.push_back(3'b011);
        en_bit <= 1;
        en_pin_n <= 0;
        drain(20);
        chk("ind_charging", 16'h0, 16'({ind, ind_oe_n}));
        thr <= 1;
        cyc(5);
        chk("half_rate", 16'h1, 16'(half));
        exp_q.push_back(3'b100);
        vset <= 16'h1068;
        drain(20);
        cyc(20);
        chk("term_inhibit", 16'h4, 16'(code));
        exp_q.push_back(3'b111);
        thr <= 0;
        drain(20);
        chk("ind_done", 16'h1, 16'(ind));
        $display("test full cycle done");
        // recharge below target minus 200 mV
        rsel <= 2'h3;
        vset <= 16'h0f3c;
        cyc(20);
        chk("no_recharge", 16'h7, 16'(code));
        exp_q.push_back(3'b000);
        exp_q.push_back(3'b011);
        rsel <= 2'h1;
        drain(40);
        // pin toggle restarts, thermistor fault refuses start
        exp_q.push_back(3'b000);
        en_pin_n <= 1;
        drain(20);
        therm <= 1;
        en_pin_n <= 0;
        cyc(20);
        chk("refused_start", 16'h0, 16'(code));
        therm <= 0;
        tflt <= 1;
        cyc(20);
        chk("refused_timer", 16'h0, 16'(code));
        exp_q.push_back(3'b011);
        tflt <= 0;
        drain(20);
        $display("test restart done");
        // masked pulses: watcher flags any pulse
        mask <= 1;
        en_bit <= 0;
        cyc(20);
        chk("masked_idle", 16'h0, 16'(code));
        en_bit <= 1;
        cyc(20);
        ind_dis <= 1;
        cyc(5);
        chk("ind_release", 16'h1, 16'(ind_oe_n));
        ind_dis <= 0;
        en_bit <= 0;
        cyc(20);
        mask <= 0;
        $display("test mask done");
        // trickle, hold at 2.5 V, then pre-charge after the hold
        vset <= 16'h05dc;
        exp_q.push_back(3'b001);
        cyc(2);
        en_bit <= 1;
        drain(20);
        lpd <= 1;
        cyc(4);
        chk("trickle_ldo", 16'h2, 16'({msh, ccl}));
        lpd <= 0;
        vset <= 16'h08fc;
        cyc(6);
        chk("cell_hold", 16'h1, 16'(hold));
        exp_q.push_back(3'b010);
        drain(45000);
        $display("test trickle done");
        // two cells: 5000 mV is below 8400*11/16 so pre-charge
        exp_q.push_back(3'b000);
        en_bit <= 0;
        drain(20);
        cells <= 2'h1;
        vset <= 16'h1388;
        exp_q.push_back(3'b010);
        cyc(2);
        en_bit <= 1;
        drain(20);
        // linear cap, then converter loop with linear pass off
        cur <= 16'h0c80;
        smin <= 1;
        cyc(6);
        chk("ldo_cap", 16'h07d0, lim);
        chk("min_sys_hold", 16'h2, 16'({msh, ccl}));
        lpd <= 1;
        cyc(6);
        chk("no_cap", 16'h0c80, lim);
        chk("conv_loop", 16'h1, 16'({msh, ccl}));
        smin <= 0;
        lpd <= 0;
        // converter stop drops to idle, restart picks pre-charge again
        exp_q.push_back(3'b000);
        conv <= 0;
        drain(20);
        exp_q.push_back(3'b010);
        conv <= 1;
        drain(20);
        // random input limit loops
        repeat (8)
        begin
            {vl, il} <= 2'($random(seed));
            cyc(6);
            chk("limit_flags", 16'({vl, il}), 16'({vf, cf}));
        end
        // supplement mode while disabled
        exp_q.push_back(3'b000);
        en_bit <= 0;
        drain(20);
        sbat <= 1;
        cyc(6);
        chk("supplement_on", 16'h1, 16'(sw));
        depl <= 1;
        cyc(6);
        chk("supplement_off", 16'h0, 16'(sw));
        $display("test power path done");
        complete_run();
    end
endmodule
